// File: rtl/lbmjc_top.sv
// Purpose: Channel 0 loopback selection, line monitoring and jitter peak capture
// Assumes: Inband detector, jitter demodulator and generators sit outside, on sys_clk_in
// Notes: All stream outputs are registered, one cycle behind their sources
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lbmjc_top
    import lbmjc_pkg::*;
#(
    parameter int PERSIST_CYCLES = PERSIST_CYC,
    parameter int SECOND_CYCLES = SECOND_CYC,
    parameter int JIT_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire lbmjc_sym_type rx_line_pos_pin_in,
    input wire lbmjc_sym_type tx_sys_in,
    input wire lbmjc_sym_type tx_jitter_att_in,
    input wire lbmjc_sym_type rx_jitter_att_in,
    input wire lbmjc_sym_type rx_pattern_in,
    input wire logic rx_pattern_en_in,
    input wire lbmjc_sym_type tx_pattern_in,
    input wire logic tx_pattern_en_in,
    input wire lbmjc_sym_type rx_ais_in,
    input wire logic rx_ais_en_in,
    input wire lbmjc_sym_type tx_ais_in,
    input wire logic tx_ais_en_in,
    input wire logic ib_activate_det_in,
    input wire logic ib_deactivate_det_in,
    input wire lbmjc_sym_type [15:1] mon_rx_in,
    input wire lbmjc_sym_type [15:1] mon_tx_in,
    input wire logic rx_jitter_att_en_in,
    input wire logic signed [JIT_W-1:0] jitter_sample_in,
    input wire logic jitter_valid_in,
    output lbmjc_sym_type tx_line_pos_pin_out,
    output lbmjc_sym_type rx_decoder_out,
    output lbmjc_sym_type rx_system_out,
    output lbmjc_sym_type rx_los_ais_mon_out,
    output lbmjc_sym_type tx_detect_out,
    output logic tx_clk_status_ignore_out,
    output logic [2:0] rx_term_sel_out,
    output logic jitter_bandwidth_sel_out,
    output logic second_tick_event_out
);
    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] loop_ctrl_ff;
    logic pattern_detect_dir_ff;
    logic [5:0] monitor_select_ff;
    logic [2:0] rx_term_ff;
    logic [2:0] jitter_meas_ff;
    logic second_tick_flag_ff;
    logic second_tick_mask_ff;
    logic [7:0] rdata_ff;
    logic auto_loop_active_ff;
    logic [JIT_W-1:0] pos_buf_ff;
    logic [JIT_W-1:0] neg_buf_ff;
    logic [JIT_W-1:0] pos_res_ff;
    logic [JIT_W-1:0] neg_res_ff;

    wire analog_loop_en = loop_ctrl_ff[ANALOG_LOOP_BIT];
    wire remote_loop_manual_en = loop_ctrl_ff[REMOTE_LOOP_BIT];
    wire digital_loop_manual_en = loop_ctrl_ff[DIGITAL_LOOP_BIT];
    wire auto_loop_en = loop_ctrl_ff[AUTO_LOOP_BIT];
    wire jitter_period_auto = jitter_meas_ff[JIT_AUTO_BIT];
    wire jitter_capture_strobe = jitter_meas_ff[JIT_STOP_BIT];

    wire wr_loop = reg_wr_in && reg_addr_in == LOOP_CTRL_OFS;
    wire wr_pd = reg_wr_in && reg_addr_in == PATTERN_DETECT_REG_OFS;
    wire wr_mon = reg_wr_in && reg_addr_in == MONITOR_SEL_OFS;
    wire wr_rcf = reg_wr_in && reg_addr_in == RX_CONFIG_REG_OFS;
    wire wr_jm = reg_wr_in && reg_addr_in == JITTER_MEAS_REG_OFS;
    wire wr_tm = reg_wr_in && reg_addr_in == TIMER_INT_STATUS_REG_OFS;
    wire wr_gcf = reg_wr_in && reg_addr_in == GLOBAL_CONFIG_REG_OFS;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            loop_ctrl_ff <= REG_RST;
            pattern_detect_dir_ff <= 1'b0;
            monitor_select_ff <= 6'h00;
            rx_term_ff <= 3'h0;
            jitter_meas_ff <= 3'h0;
            second_tick_mask_ff <= GCF_RST[TICK_MASK_BIT];
        end else begin
            if (wr_loop) loop_ctrl_ff <= {4'h0, reg_wdata_in[3:0]};
            if (wr_pd) pattern_detect_dir_ff <= reg_wdata_in[PATTERN_DIR_BIT];
            if (wr_mon) monitor_select_ff <= reg_wdata_in[5:0];
            if (wr_rcf) rx_term_ff <= reg_wdata_in[2:0];
            if (wr_jm) jitter_meas_ff <= reg_wdata_in[2:0];
            if (wr_gcf) second_tick_mask_ff <= reg_wdata_in[TICK_MASK_BIT];
        end
    end

    // ----------------------------------------
    // Read port, data one cycle after strobe
    // ----------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr_in)
            LOOP_CTRL_OFS: rd_mux = loop_ctrl_ff;
            PATTERN_DETECT_REG_OFS: rd_mux = {4'h0, pattern_detect_dir_ff, 3'h0};
            CHANNEL_STATUS_REG_A_OFS: rd_mux = {auto_loop_active_ff, 7'h00};
            MONITOR_SEL_OFS: rd_mux = {2'h0, monitor_select_ff};
            RX_CONFIG_REG_OFS: rd_mux = {5'h00, rx_term_ff};
            JITTER_MEAS_REG_OFS: rd_mux = {5'h00, jitter_meas_ff};
            POS_PEAK_HIGH_OFS: rd_mux = pos_res_ff[15:8];
            POS_PEAK_LOW_OFS: rd_mux = pos_res_ff[7:0];
            NEG_PEAK_HIGH_OFS: rd_mux = neg_res_ff[15:8];
            NEG_PEAK_LOW_OFS: rd_mux = neg_res_ff[7:0];
            TIMER_INT_STATUS_REG_OFS: rd_mux = {7'h00, second_tick_flag_ff};
            GLOBAL_CONFIG_REG_OFS: rd_mux = {7'h00, second_tick_mask_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) rdata_ff <= 8'h00;
        else rdata_ff <= reg_rd_in ? rd_mux : 8'h00;
    end
    assign reg_rdata_out = rdata_ff;

    // ----------------------------------------
    // Automatic loopback from inband codes
    // ----------------------------------------
    // Detector flags already apply the one-percent error tolerance
    logic [31:0] act_cnt_ff;
    logic [31:0] deact_cnt_ff;
    wire act_done = act_cnt_ff == 32'(PERSIST_CYCLES);
    wire deact_done = deact_cnt_ff == 32'(PERSIST_CYCLES);

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            act_cnt_ff <= 32'h0;
            deact_cnt_ff <= 32'h0;
        end else begin
            act_cnt_ff <= !(ib_activate_det_in && auto_loop_en) ? 32'h0 : act_cnt_ff + 32'(!act_done);
            deact_cnt_ff <= !(ib_deactivate_det_in && auto_loop_en) ? 32'h0 : deact_cnt_ff + 32'(!deact_done);
        end
    end

    // Held beyond the limit: one cycle past the full count
    wire nxt_auto_loop_active = !auto_loop_en ? 1'b0
        : (act_done && ib_activate_det_in) ? 1'b1
        : (deact_done && ib_deactivate_det_in) ? 1'b0
        : auto_loop_active_ff;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) auto_loop_active_ff <= 1'b0;
        else auto_loop_active_ff <= nxt_auto_loop_active;
    end

    // Direction is read live, so it must stay put while automatic loopback runs
    wire remote_active = !analog_loop_en
        && (remote_loop_manual_en || (auto_loop_active_ff && !pattern_detect_dir_ff));
    wire digital_active = !analog_loop_en
        && (digital_loop_manual_en || (auto_loop_active_ff && pattern_detect_dir_ff));

    // ----------------------------------------
    // Line monitoring source select
    // ----------------------------------------
    // Codes 1-15 pick a receiver, 17-31 a transmitter; bit 5 is ignored, and a zero low nibble idles
    wire [3:0] mon_chan = monitor_select_ff[3:0];
    wire mon_active = monitor_select_ff != 6'h00 && mon_chan != 4'h0;
    wire lbmjc_sym_type mon_sym = monitor_select_ff[4] ? mon_tx_in[mon_chan] : mon_rx_in[mon_chan];
    // Only our own input is swapped; the watched channel is untouched
    wire lbmjc_sym_type line_in = mon_active ? mon_sym : rx_line_pos_pin_in;

    // ----------------------------------------
    // Datapath substitution and priority
    // ----------------------------------------
    lbmjc_sym_type nxt_tx_line;
    lbmjc_sym_type nxt_rx_dec;
    lbmjc_sym_type nxt_rx_sys;
    always_comb begin
        if (tx_pattern_en_in) nxt_tx_line = tx_pattern_in;
        else if (remote_active) nxt_tx_line = rx_jitter_att_in;
        else if (tx_ais_en_in && !analog_loop_en && !digital_active) nxt_tx_line = tx_ais_in;
        else nxt_tx_line = tx_jitter_att_in;
    end

    always_comb begin
        if (digital_active) nxt_rx_dec = tx_jitter_att_in;
        else if (analog_loop_en) nxt_rx_dec = nxt_tx_line;
        else nxt_rx_dec = line_in;
    end

    // AIS on receive is only allowed in normal and remote operation
    wire rx_ais_ok = !analog_loop_en && !digital_active;
    always_comb begin
        if (rx_pattern_en_in) nxt_rx_sys = rx_pattern_in;
        else if (rx_ais_en_in && rx_ais_ok) nxt_rx_sys = rx_ais_in;
        else nxt_rx_sys = nxt_rx_dec;
    end

    lbmjc_sym_type tx_line_ff;
    lbmjc_sym_type rx_dec_ff;
    lbmjc_sym_type rx_sys_ff;
    lbmjc_sym_type rx_mon_ff;
    lbmjc_sym_type tx_det_ff;
    logic tx_clk_ign_ff;
    logic [2:0] term_ff;
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_line_ff <= '0;
            rx_dec_ff <= '0;
            rx_sys_ff <= '0;
            rx_mon_ff <= '0;
            tx_det_ff <= '0;
            tx_clk_ign_ff <= 1'b0;
            term_ff <= 3'h0;
        end else begin
            tx_line_ff <= nxt_tx_line;
            rx_dec_ff <= nxt_rx_dec;
            rx_sys_ff <= nxt_rx_sys;
            rx_mon_ff <= analog_loop_en ? nxt_tx_line : line_in;
            tx_det_ff <= tx_sys_in;
            tx_clk_ign_ff <= remote_active;
            term_ff <= mon_active ? TERM_EXTERNAL : rx_term_ff;
        end
    end
    assign tx_line_pos_pin_out = tx_line_ff;
    assign rx_decoder_out = rx_dec_ff;
    assign rx_system_out = rx_sys_ff;
    assign rx_los_ais_mon_out = rx_mon_ff;
    assign tx_detect_out = tx_det_ff;
    assign tx_clk_status_ignore_out = tx_clk_ign_ff;
    assign rx_term_sel_out = term_ff;

    // ----------------------------------------
    // Jitter peak measurement
    // ----------------------------------------
    logic [31:0] sec_cnt_ff;
    logic stop_d_ff;
    wire sec_tick = jitter_period_auto && sec_cnt_ff == 32'(SECOND_CYCLES - 1);
    wire stop_rise = !jitter_period_auto && jitter_capture_strobe && !stop_d_ff;
    wire transfer = sec_tick || stop_rise;
    wire meas_en = rx_jitter_att_en_in && jitter_valid_in;
    wire sample_neg = jitter_sample_in[JIT_W-1];
    wire [JIT_W-1:0] sample_mag = sample_neg ? JIT_W'(-jitter_sample_in) : JIT_W'(jitter_sample_in);
    wire pos_new = meas_en && !sample_neg && sample_mag > pos_buf_ff;
    wire neg_new = meas_en && sample_neg && sample_mag > neg_buf_ff;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sec_cnt_ff <= 32'h0;
            stop_d_ff <= 1'b0;
        end else begin
            sec_cnt_ff <= (!jitter_period_auto || sec_tick) ? 32'h0 : sec_cnt_ff + 32'h1;
            stop_d_ff <= jitter_capture_strobe;
        end
    end

    // Transfer restarts the buffers empty, so a peak in that cycle is dropped
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pos_buf_ff <= PEAK_RST;
            neg_buf_ff <= PEAK_RST;
            pos_res_ff <= PEAK_RST;
            neg_res_ff <= PEAK_RST;
        end else if (transfer) begin
            pos_res_ff <= pos_buf_ff;
            neg_res_ff <= neg_buf_ff;
            pos_buf_ff <= PEAK_RST;
            neg_buf_ff <= PEAK_RST;
        end else begin
            if (pos_new) pos_buf_ff <= sample_mag;
            if (neg_new) neg_buf_ff <= sample_mag;
        end
    end

    // Set wins over a same-cycle write-one clear
    wire nxt_tick_flag = sec_tick || (second_tick_flag_ff && !(wr_tm && reg_wdata_in[TICK_FLAG_BIT]));
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) second_tick_flag_ff <= 1'b0;
        else second_tick_flag_ff <= nxt_tick_flag;
    end
    assign second_tick_event_out = second_tick_flag_ff && !second_tick_mask_ff;
    assign jitter_bandwidth_sel_out = jitter_meas_ff[JIT_BW_BIT];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_stop_rise;
        !jitter_capture_strobe ##1 (jitter_capture_strobe && !jitter_period_auto);
    endsequence
    sequence s_act_held;
        auto_loop_en && ib_activate_det_in && act_done;
    endsequence

    property p_analog_override;
        @(posedge sys_clk_in) disable iff (sys_rst_in) analog_loop_en |-> !remote_active && !digital_active;
    endproperty
    a_analog_override: assert property (p_analog_override) else $error("loop active under analog");

    property p_analog_loopback;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
            analog_loop_en && !digital_active |=> rx_decoder_out == tx_line_pos_pin_out;
    endproperty
    a_analog_loopback: assert property (p_analog_loopback) else $error("analog loop data mismatch");

    property p_remote_source;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
            remote_active == (!analog_loop_en && (remote_loop_manual_en
            || (auto_loop_active_ff && !pattern_detect_dir_ff)));
    endproperty
    a_remote_source: assert property (p_remote_source) else $error("remote enable wrong");

    property p_auto_drop;
        @(posedge sys_clk_in) disable iff (sys_rst_in) $fell(auto_loop_en) |=> !auto_loop_active_ff;
    endproperty
    a_auto_drop: assert property (p_auto_drop) else $error("auto loop not dropped");

    property p_auto_enter;
        @(posedge sys_clk_in) disable iff (sys_rst_in) s_act_held |=> auto_loop_active_ff;
    endproperty
    a_auto_enter: assert property (p_auto_enter) else $error("auto loop not entered");

    property p_tx_detect;
        @(posedge sys_clk_in) disable iff (sys_rst_in) !$past(sys_rst_in) |-> tx_detect_out == $past(tx_sys_in);
    endproperty
    a_tx_detect: assert property (p_tx_detect) else $error("tx detector not on system data");

    property p_remote_pattern;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
            remote_active && tx_pattern_en_in |=> tx_line_pos_pin_out == $past(tx_pattern_in);
    endproperty
    a_remote_pattern: assert property (p_remote_pattern) else $error("tx pattern lost");

    property p_mon_term;
        @(posedge sys_clk_in) disable iff (sys_rst_in) mon_active |=> rx_term_sel_out == TERM_EXTERNAL;
    endproperty
    a_mon_term: assert property (p_mon_term) else $error("termination not external");

    property p_sec_capture;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
            sec_tick |=> second_tick_flag_ff && pos_res_ff == $past(pos_buf_ff) && pos_buf_ff == PEAK_RST;
    endproperty
    a_sec_capture: assert property (p_sec_capture) else $error("second capture failed");

    property p_manual_capture;
        @(posedge sys_clk_in) disable iff (sys_rst_in) s_stop_rise |=> neg_res_ff == $past(neg_buf_ff);
    endproperty
    a_manual_capture: assert property (p_manual_capture) else $error("manual capture failed");

    property p_status_read;
        @(posedge sys_clk_in) disable iff (sys_rst_in)
            reg_rd_in && reg_addr_in == CHANNEL_STATUS_REG_A_OFS |=> reg_rdata_out[7] == $past(auto_loop_active_ff);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bit wrong");
endmodule // lbmjc_top
`default_nettype wire

// File: include/lbmjc_pkg.sv
// Purpose: Shared constants and types for the loopback, monitor and jitter block
// Assumes: 100 MHz system clock, 8-bit register port
// Notes: Offsets are register indices on the plain register port
package lbmjc_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int PERSIST_MS = 5100;
    localparam int SECOND_MS = 1000;
    localparam int PERSIST_CYC = PERSIST_MS * (CLK_HZ / 1000);
    localparam int SECOND_CYC = SECOND_MS * (CLK_HZ / 1000);
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] LOOP_CTRL_OFS = 5'h00;
    localparam logic [4:0] PATTERN_DETECT_REG_OFS = 5'h01;
    localparam logic [4:0] CHANNEL_STATUS_REG_A_OFS = 5'h02;
    localparam logic [4:0] MONITOR_SEL_OFS = 5'h03;
    localparam logic [4:0] RX_CONFIG_REG_OFS = 5'h04;
    localparam logic [4:0] JITTER_MEAS_REG_OFS = 5'h05;
    localparam logic [4:0] POS_PEAK_HIGH_OFS = 5'h06;
    localparam logic [4:0] POS_PEAK_LOW_OFS = 5'h07;
    localparam logic [4:0] NEG_PEAK_HIGH_OFS = 5'h08;
    localparam logic [4:0] NEG_PEAK_LOW_OFS = 5'h09;
    localparam logic [4:0] TIMER_INT_STATUS_REG_OFS = 5'h0A;
    localparam logic [4:0] GLOBAL_CONFIG_REG_OFS = 5'h0B;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ANALOG_LOOP_BIT = 0;
    localparam int REMOTE_LOOP_BIT = 1;
    localparam int DIGITAL_LOOP_BIT = 2;
    localparam int AUTO_LOOP_BIT = 3;
    localparam int PATTERN_DIR_BIT = 3;
    localparam int AUTO_ACTIVE_BIT = 7;
    localparam int JIT_BW_BIT = 0;
    localparam int JIT_AUTO_BIT = 1;
    localparam int JIT_STOP_BIT = 2;
    localparam int TICK_FLAG_BIT = 0;
    localparam int TICK_MASK_BIT = 0;
    // ----------------------------------------
    // Reset values and codes
    // ----------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] GCF_RST = 8'h01;
    localparam logic [2:0] TERM_EXTERNAL = 3'h0;
    localparam logic [15:0] PEAK_RST = 16'h0000;

    typedef struct packed {
        logic pos;
        logic neg;
    } lbmjc_sym_type;
endpackage

// File: verif/lbmjc_far_model.sv
// Purpose: Far-side stream sources for the loopback block
// Assumes: One source is hot at a time, chosen by sel_in
// Notes: Cold sources carry the inverse symbol so a wrong path shows
`timescale 1ns/1ps
`default_nettype none
module lbmjc_far_model
    import lbmjc_pkg::*;
(
    input wire logic [5:0] sel_in,
    output lbmjc_sym_type [7:0] src_out,
    output lbmjc_sym_type [15:1] mrx_out,
    output lbmjc_sym_type [15:1] mtx_out
);
    for (genvar i = 0; i < 8; i++) begin : g_src
        assign src_out[i] = (sel_in == 6'(i)) ? 2'h2 : 2'h1;
    end
    for (genvar i = 1; i < 16; i++) begin : g_mon
        assign mrx_out[i] = (sel_in == 6'(8 + i)) ? 2'h2 : 2'h1;
        assign mtx_out[i] = (sel_in == 6'(24 + i)) ? 2'h2 : 2'h1;
    end
endmodule // lbmjc_far_model
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for loopback, monitor and jitter capture
// Assumes: Short persistence and second counts for run time
// Notes: Source index 0 line,1 sys,2 tja,3 rja,4 rpat,5 tpat,6 rais,7 tais
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module tb_top import lbmjc_pkg::*; ;
    localparam lbmjc_sym_type H = 2'h2;
    localparam lbmjc_sym_type C = 2'h1;
    logic clk = 0, rst = 1, wr = 0, rd = 0, iba = 0, ibd = 0, jv = 0, jen = 1;
    logic rpe = 0, tpe = 0, rae = 0, tae = 0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wd = 8'h00, rv, rdata;
    logic [5:0] sel = 6'h00;
    logic signed [15:0] js = 16'sh0000;
    int fail_count = 0, tests_run = 0;
    lbmjc_sym_type txl, dec, rxs, lam, tdet;
    lbmjc_sym_type [7:0] src;
    lbmjc_sym_type [15:1] mrx, mtx;
    logic ign, bw, tick;
    logic [2:0] term;
    always #5 clk = ~clk;
    lbmjc_far_model lbmjc_far_model_inst (.sel_in(sel), .src_out(src), .mrx_out(mrx), .mtx_out(mtx));
    lbmjc_top #(.PERSIST_CYCLES(20), .SECOND_CYCLES(16)) lbmjc_top_inst (.sys_clk_in(clk), .sys_rst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .rx_line_pos_pin_in(src[0]), .tx_sys_in(src[1]), .tx_jitter_att_in(src[2]), .rx_jitter_att_in(src[3]),
        .rx_pattern_in(src[4]), .rx_pattern_en_in(rpe), .tx_pattern_in(src[5]), .tx_pattern_en_in(tpe),
        .rx_ais_in(src[6]), .rx_ais_en_in(rae), .tx_ais_in(src[7]), .tx_ais_en_in(tae),
        .ib_activate_det_in(iba), .ib_deactivate_det_in(ibd), .mon_rx_in(mrx), .mon_tx_in(mtx),
        .rx_jitter_att_en_in(jen), .jitter_sample_in(js), .jitter_valid_in(jv), .tx_line_pos_pin_out(txl),
        .rx_decoder_out(dec), .rx_system_out(rxs), .rx_los_ais_mon_out(lam), .tx_detect_out(tdet),
        .tx_clk_status_ignore_out(ign), .rx_term_sel_out(term), .jitter_bandwidth_sel_out(bw),
        .second_tick_event_out(tick));
    // ----------------------------------------
    // Bus and stream helpers
    // ----------------------------------------
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rreg(input logic [4:0] a);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic en(input logic [3:0] e);
        @(posedge clk) {rpe, tpe, rae, tae} <= e;
    endtask
    // Three edges let the registered datapath settle
    task automatic st(input logic [5:0] s);
        @(posedge clk) sel <= s;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        rreg(CHANNEL_STATUS_REG_A_OFS);
        `CHK("stat", 8'h00, rv)
        rreg(GLOBAL_CONFIG_REG_OFS);
        `CHK("gcf", GCF_RST, rv)
        rreg(5'h1F);
        `CHK("unmapped", 8'h00, rv)
        $display("test reset done");
    endtask
    task automatic t_analog;
        wreg(LOOP_CTRL_OFS, 8'h07);
        en(4'b0011);
        st(2);
        `CHK("txl", H, txl)
        `CHK("dec", H, dec)
        `CHK("lam", H, lam)
        st(3);
        `CHK("txl_rja", C, txl)
        `CHK("ign", 1'b0, ign)
        st(7);
        `CHK("txl_ais", C, txl)
        st(6);
        `CHK("rxs_ais", C, rxs)
        en(4'b1011);
        st(4);
        `CHK("rxs_pat", H, rxs)
        $display("test analog done");
    endtask
    task automatic t_remote;
        en(4'b0000);
        wreg(LOOP_CTRL_OFS, 8'h02);
        st(3);
        `CHK("txl", H, txl)
        `CHK("ign", 1'b1, ign)
        st(1);
        `CHK("tdet", H, tdet)
        `CHK("txl_sys", C, txl)
        st(0);
        `CHK("rxs", H, rxs)
        en(4'b0001);
        st(7);
        `CHK("txl_ais", C, txl)
        en(4'b0100);
        st(5);
        `CHK("txl_pat", H, txl)
        en(4'b1010);
        st(6);
        `CHK("rxs_pat", C, rxs)
        $display("test remote done");
    endtask
    task automatic t_digital;
        en(4'b0000);
        wreg(LOOP_CTRL_OFS, 8'h04);
        st(2);
        `CHK("dec", H, dec)
        `CHK("txl", H, txl)
        st(0);
        `CHK("lam", H, lam)
        `CHK("dec_line", C, dec)
        en(4'b0001);
        st(7);
        `CHK("txl_ais", C, txl)
        en(4'b0010);
        st(6);
        `CHK("rxs_ais", C, rxs)
        en(4'b1100);
        st(4);
        `CHK("rxs_pat", H, rxs)
        st(5);
        `CHK("txl_pat", H, txl)
        $display("test digital done");
    endtask
    // Direction is only changed while no automatic loop is up
    task automatic t_auto;
        en(4'b0000);
        wreg(PATTERN_DETECT_REG_OFS, 8'h00);
        wreg(LOOP_CTRL_OFS, 8'h08);
        @(posedge clk) iba <= 1'b1;
        repeat (8) @(posedge clk);
        rreg(CHANNEL_STATUS_REG_A_OFS);
        `CHK("early", 8'h00, rv)
        repeat (15) @(posedge clk);
        rreg(CHANNEL_STATUS_REG_A_OFS);
        `CHK("act", 8'h80, rv)
        `CHK("ign", 1'b1, ign)
        @(posedge clk) {iba, ibd} <= 2'h1;
        repeat (25) @(posedge clk);
        rreg(CHANNEL_STATUS_REG_A_OFS);
        `CHK("deact", 8'h00, rv)
        @(posedge clk) {iba, ibd} <= 2'h2;
        repeat (25) @(posedge clk);
        wreg(LOOP_CTRL_OFS, 8'h00);
        rreg(CHANNEL_STATUS_REG_A_OFS);
        `CHK("off", 8'h00, rv)
        wreg(PATTERN_DETECT_REG_OFS, 8'h08);
        wreg(LOOP_CTRL_OFS, 8'h08);
        repeat (25) @(posedge clk);
        st(2);
        `CHK("dec", H, dec)
        wreg(LOOP_CTRL_OFS, 8'h00);
        @(posedge clk) iba <= 1'b0;
        $display("test auto done");
    endtask
    task automatic t_mon;
        wreg(RX_CONFIG_REG_OFS, 8'h05);
        wreg(MONITOR_SEL_OFS, 8'h03);
        st(11);
        `CHK("rxs", H, rxs)
        `CHK("lam", H, lam)
        `CHK("term", TERM_EXTERNAL, term)
        wreg(MONITOR_SEL_OFS, 8'h13);
        st(27);
        `CHK("rxs_tx", H, rxs)
        wreg(MONITOR_SEL_OFS, 8'h00);
        st(0);
        `CHK("rxs_line", H, rxs)
        `CHK("term_own", 3'h5, term)
        $display("test monitor done");
    endtask
    task automatic t_jit;
        wreg(JITTER_MEAS_REG_OFS, 8'h01);
        #1;
        `CHK("bw", 1'b1, bw)
        @(posedge clk) {js, jv} <= {16'sh0030, 1'b1};
        @(posedge clk) js <= -16'sh0050;
        @(posedge clk) jv <= 1'b0;
        wreg(JITTER_MEAS_REG_OFS, 8'h05);
        rreg(POS_PEAK_LOW_OFS);
        `CHK("pl", 8'h30, rv)
        rreg(POS_PEAK_HIGH_OFS);
        `CHK("ph", 8'h00, rv)
        rreg(NEG_PEAK_LOW_OFS);
        `CHK("nl", 8'h50, rv)
        wreg(JITTER_MEAS_REG_OFS, 8'h01);
        wreg(JITTER_MEAS_REG_OFS, 8'h05);
        rreg(POS_PEAK_LOW_OFS);
        `CHK("pl_clr", 8'h00, rv)
        wreg(GLOBAL_CONFIG_REG_OFS, 8'h00);
        wreg(JITTER_MEAS_REG_OFS, 8'h02);
        repeat (20) @(posedge clk);
        #1;
        `CHK("tick", 1'b1, tick)
        rreg(TIMER_INT_STATUS_REG_OFS);
        `CHK("flag", 8'h01, rv)
        wreg(TIMER_INT_STATUS_REG_OFS, 8'h01);
        rreg(TIMER_INT_STATUS_REG_OFS);
        `CHK("flag_clr", 8'h00, rv)
        $display("test jitter done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_analog();
        t_remote();
        t_digital();
        t_auto();
        t_mon();
        t_jit();
        end_of_test();
    end
    // Run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
